// ===== pkg/ipa_cfg.svh
// Offsets, field layout, reset values and vector map of the priority arbiter
`ifndef IPA_CFG_SVH
`define IPA_CFG_SVH

// Byte addresses of the four priority registers in the data space
`define IPA_OFS_GROUP0     8'h1C
`define IPA_OFS_GROUP1     8'h1D
`define IPA_OFS_GROUP2     8'h1E
`define IPA_OFS_GROUP3     8'h1F

// Register reset value and the read-only top nibble of the fourth register
`define IPA_PRIO_RESET     8'hFF
`define IPA_GROUP3_RO_MASK 8'hF0

// Number of maskable vectors and fields packed per register
`define IPA_NUM_VEC        14
`define IPA_FIELDS_PER_REG 4

// Field pairs {high, low}
`define IPA_PAIR_LEVEL0    2'b10
`define IPA_PAIR_LEVEL1    2'b01
`define IPA_PAIR_LEVEL2    2'b00
`define IPA_PAIR_LEVEL3    2'b11

// Vector addresses: reset, trap, index 0; each next index is two bytes lower
`define IPA_VEC_RESET      16'hFFFE
`define IPA_VEC_TRAP       16'hFFFC
`define IPA_VEC_BASE       16'hFFFA
`define IPA_VEC_STEP       16'h0002

// Indexes wired to a source, and those that can wake from deepest stop
`define IPA_USED_MASK      14'h0CFB
`define IPA_WAKE_MASK      14'h002A

`endif

// ===== pkg/ipa_pkg.sv
// Types shared by the priority arbiter modules
package ipa_pkg;

  // Arbiter sequencing
  typedef enum logic [1:0] {
    IPA_ST_BOOT = 2'b00,
    IPA_ST_RUN  = 2'b01
  } ipa_state_t;

  // Kind of vector handed to the CPU
  typedef enum logic [1:0] {
    IPA_SRC_RESET = 2'b00,
    IPA_SRC_TRAP  = 2'b01,
    IPA_SRC_MASK  = 2'b10
  } ipa_src_t;

  typedef logic [1:0] ipa_pair_t;

endpackage : ipa_pkg

// ===== sim/interrupt_priority_arbiter_bench.sv
// Self-checking bench of the interrupt priority arbiter
`timescale 1ns/100ps

module interrupt_priority_arbiter_bench;
  import ipa_pkg::*;
  logic        sys_clk, rstn, regWr, regRd, trapReq, haltMode, run, lvlWr;
  logic        instrBoundary, curPrioHighBit, curPrioLowBit, svcValid;
  logic        newPrioHighBit, newPrioLowBit, wakeReq, maskPending;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic [13:0] irqPending, irqEnable;
  logic [1:0]  lvlIn;
  logic [3:0]  svcIndex;
  logic [15:0] svcVector;
  ipa_src_t    svcKind;
  int          err_count, compares, cycles;

  interrupt_priority_arbiter dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .irqPending(irqPending), .irqEnable(irqEnable),
    .trapReq(trapReq), .instrBoundary(instrBoundary), .curPrioHighBit(curPrioHighBit),
    .curPrioLowBit(curPrioLowBit), .haltMode(haltMode), .svcValid(svcValid),
    .svcKind(svcKind), .svcIndex(svcIndex), .svcVector(svcVector),
    .newPrioHighBit(newPrioHighBit), .newPrioLowBit(newPrioLowBit), .wakeReq(wakeReq),
    .maskPending(maskPending));
  ipa_cpu_model cpu_u (
    .sys_clk(sys_clk), .rstn(rstn), .run(run), .lvlWr(lvlWr), .lvlIn(lvlIn),
    .svcValid(svcValid), .newPrioHighBit(newPrioHighBit), .newPrioLowBit(newPrioLowBit),
    .instrBoundary(instrBoundary), .curPrioHighBit(curPrioHighBit),
    .curPrioLowBit(curPrioLowBit));

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    @(negedge sys_clk);
    chk("regRdata", {8'h00, regRdata}, {8'h00, exp});
  endtask : rd

  // Software sets the CPU level, optionally with new sources
  task automatic setlv(input logic [1:0] p, input logic [13:0] src, input logic t, h);
    @(posedge sys_clk);
    lvlIn      <= p;
    lvlWr      <= 1'b1;
    irqPending <= src;
    irqEnable  <= src;
    trapReq    <= t;
    haltMode   <= h;
    @(posedge sys_clk);
    lvlWr      <= 1'b0;
  endtask : setlv

  task automatic exp_svc(input logic want, input ipa_src_t k, input logic [3:0] idx,
                         input logic [15:0] vec, input logic [1:0] pr);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 12 && !got; i++)
    begin
      @(negedge sys_clk);
      got = (svcValid === 1'b1);
    end
    chk("svcValid", got, want);
    if (got && want)
    begin
      chk("svcKind", svcKind, k);
      chk("svcIndex", svcIndex, idx);
      chk("svcVector", svcVector, vec);
      chk("newPrio", {newPrioHighBit, newPrioLowBit}, pr);
    end
  endtask : exp_svc

  // Reset vector is served once right after release
  task automatic t_reset();
    exp_svc(1'b1, IPA_SRC_RESET, 4'h0, 16'hFFFE, 2'b11);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    chk("maskPending", maskPending, 1'b0);
    for (int a = 0; a < 4; a++)
      rd(8'h1C + a[7:0], 8'hFF);
    wr(8'h1C, 8'hCF);
    wr(8'h1C, 8'h64);
    rd(8'h1C, 8'h44);
    wr(8'h1F, 8'h00);
    rd(8'h1F, 8'hF0);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h1C, 8'h44);
    $display("test regs done");
  endtask : t_regs

  task automatic t_nest();
    wr(8'h1D, 8'hFD);
    setlv(2'b10, 14'h0018, 1'b0, 1'b0);
    exp_svc(1'b1, IPA_SRC_MASK, 4'h3, 16'hFFF4, 2'b01);
    exp_svc(1'b0, IPA_SRC_MASK, 4'h0, 16'h0000, 2'b00);
    wr(8'h1C, 8'h04);
    exp_svc(1'b1, IPA_SRC_MASK, 4'h3, 16'hFFF4, 2'b00);
    wr(8'h1C, 8'h44);
    exp_svc(1'b0, IPA_SRC_MASK, 4'h0, 16'h0000, 2'b00);
    wr(8'h1D, 8'hFC);
    setlv(2'b10, 14'h0018, 1'b0, 1'b0);
    exp_svc(1'b1, IPA_SRC_MASK, 4'h4, 16'hFFF2, 2'b00);
    $display("test nest done");
  endtask : t_nest

  task automatic t_trap();
    setlv(2'b10, 14'h0010, 1'b1, 1'b0);
    exp_svc(1'b1, IPA_SRC_TRAP, 4'h0, 16'hFFFC, 2'b11);
    @(posedge sys_clk);
    trapReq <= 1'b0;
    setlv(2'b10, 14'h0010, 1'b0, 1'b0);
    exp_svc(1'b1, IPA_SRC_MASK, 4'h4, 16'hFFF2, 2'b00);
    $display("test trap done");
  endtask : t_trap

  task automatic t_halt();
    wr(8'h1D, 8'hF4);
    setlv(2'b10, 14'h0030, 1'b0, 1'b1);
    exp_svc(1'b1, IPA_SRC_MASK, 4'h5, 16'hFFF0, 2'b01);
    chk("wakeReq", wakeReq, 1'b1);
    chk("maskPending", maskPending, 1'b1);
    @(posedge sys_clk);
    haltMode <= 1'b0;
    exp_svc(1'b1, IPA_SRC_MASK, 4'h4, 16'hFFF2, 2'b00);
    chk("wakeReq", wakeReq, 1'b0);
    $display("test halt done");
  endtask : t_halt

  // Clock of 40 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Cuts a hang short
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_count++;
      $display("[ERR] cycles expected below 4000 seen %0d", cycles);
      end_sim();
    end
  end

  // Main sequence
  initial
  begin
    {rstn, regWr, regRd, trapReq, haltMode, run, lvlWr} = '0;
    {regAddr, regWdata, irqPending, irqEnable, lvlIn} = '0;
    {err_count, compares, cycles} = '0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    run  <= 1'b1;
    t_reset();
    t_regs();
    t_nest();
    t_trap();
    t_halt();
    end_sim();
  end
endmodule : interrupt_priority_arbiter_bench

// ===== sim/ipa_arb_sva.sv
// Port checker of the interrupt priority arbiter
`timescale 1ns/100ps
`include "ipa_cfg.svh"

module ipa_arb_sva #(
  parameter int ADDR_W  = 8,
  parameter int NUM_VEC = 14
) (
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regRd,
  input wire logic [7:0]        regRdata,
  input wire logic [13:0]       irqPending,
  input wire logic [13:0]       irqEnable,
  input wire logic              trapReq,
  input wire logic              instrBoundary,
  input wire logic              curPrioHighBit,
  input wire logic              curPrioLowBit,
  input wire logic              haltMode,
  input wire logic              svcValid,
  input wire ipa_pkg::ipa_src_t svcKind,
  input wire logic [3:0]        svcIndex,
  input wire logic [15:0]       svcVector,
  input wire logic              newPrioHighBit,
  input wire logic              newPrioLowBit,
  input wire logic              wakeReq
);
  import ipa_pkg::*;
  localparam logic [13:0] USED = `IPA_USED_MASK;
  localparam logic [13:0] WAKE = `IPA_WAKE_MASK;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Level of a {high,low} pair
  function automatic int lv(logic [1:0] p);
    return (p == 2'b10) ? 0 : (p == 2'b01) ? 1 : (p == 2'b00) ? 2 : 3;
  endfunction : lv

  svc_cause_a: assert property (
    svcValid && $past(rstn, 2) |-> $past(instrBoundary))
    else $error("service pulse without a boundary");
  nmi_level_a: assert property (
    svcValid && svcKind != IPA_SRC_MASK |-> {newPrioHighBit, newPrioLowBit} == 2'b11)
    else $error("reset or trap entry not at level three");
  vec_addr_a: assert property (
    svcValid && svcKind == IPA_SRC_MASK |-> svcVector == 16'hFFFA - {11'h000, svcIndex, 1'b0})
    else $error("maskable vector address wrong");
  trap_vec_a: assert property (
    svcValid && svcKind == IPA_SRC_TRAP |-> svcVector == 16'hFFFC && svcIndex == 4'h0)
    else $error("trap vector address wrong");
  trap_first_a: assert property (
    instrBoundary && trapReq && $past(rstn) |=> svcValid && svcKind == IPA_SRC_TRAP)
    else $error("trap not serviced first");
  used_idx_a: assert property (
    svcValid && svcKind == IPA_SRC_MASK |-> USED[svcIndex])
    else $error("unused index serviced");
  above_cur_a: assert property (
    svcValid && svcKind == IPA_SRC_MASK && $past(rstn, 2) |->
    lv({newPrioHighBit, newPrioLowBit}) > lv($past({curPrioHighBit, curPrioLowBit})))
    else $error("serviced level not above current level");
  halt_src_a: assert property (
    svcValid && svcKind == IPA_SRC_MASK && $past(haltMode) |-> WAKE[svcIndex])
    else $error("non-waking source serviced in halt");
  wake_lvl_a: assert property (
    $past(rstn) |-> wakeReq == $past(haltMode && |(irqPending & irqEnable & WAKE)))
    else $error("wake request wrong");
  ro_nibble_a: assert property (
    regRd && regAddr == `IPA_OFS_GROUP3 |=> regRdata[7:4] == 4'hF)
    else $error("read-only nibble not one");
endmodule : ipa_arb_sva

bind interrupt_priority_arbiter ipa_arb_sva #(.ADDR_W(ADDR_W), .NUM_VEC(NUM_VEC)) sva_u (
  .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
  .irqPending(irqPending), .irqEnable(irqEnable), .trapReq(trapReq),
  .instrBoundary(instrBoundary), .curPrioHighBit(curPrioHighBit),
  .curPrioLowBit(curPrioLowBit), .haltMode(haltMode), .svcValid(svcValid),
  .svcKind(svcKind), .svcIndex(svcIndex), .svcVector(svcVector),
  .newPrioHighBit(newPrioHighBit), .newPrioLowBit(newPrioLowBit), .wakeReq(wakeReq));

// ===== sim/ipa_cpu_model.sv
// CPU core stand-in: instruction boundaries and current level pair
`timescale 1ns/100ps

module ipa_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic       lvlWr,
  input  wire logic [1:0] lvlIn,
  input  wire logic       svcValid,
  input  wire logic       newPrioHighBit,
  input  wire logic       newPrioLowBit,
  output logic            instrBoundary,
  output logic            curPrioHighBit,
  output logic            curPrioLowBit
);
  logic [1:0] cnt_r;
  logic [1:0] cc_r;

  // Boundary every fourth cycle; level loaded on entry or by software
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cnt_r <= 2'h0;
      cc_r  <= 2'h3;
    end
    else
    begin
      cnt_r <= cnt_r + 2'h1;
      if (svcValid)
        cc_r <= {newPrioHighBit, newPrioLowBit};
      else if (lvlWr)
        cc_r <= lvlIn;
    end
  end

  // Level pair and boundary outputs
  assign instrBoundary  = run && (cnt_r == 2'h3);
  assign curPrioHighBit = cc_r[1];
  assign curPrioLowBit  = cc_r[0];
endmodule : ipa_cpu_model

// ===== verilog/interrupt_priority_arbiter.sv
// Interrupt priority arbiter: software priority registers and vector selection
// Notes on behaviour
// - Four byte registers, four 2-bit fields each, lowest index in low bits.
// - Each maskable vector owns one field; reset and trap own none.
// - All priority registers reset to all ones.
// - Top nibble of fourth register reads one and ignores writes.
// - Stored fields share the CPU current-level encoding.
// - Writing the lowest-level pair leaves that field unchanged.
// - Reset and trap carry no programmable priority.
// - Servicing reset or trap loads both current-level bits set.
// - Raised priority of a running, still pending vector re-enters it.
// - Other priority changes leave the level in effect unchanged.
// - Reset at top vector, trap below, then index 0 downward.
// - Hardware order: reset, trap, then maskables by increasing index.
// - Fixed mapping of sources to indexes; 2, 8, 9, 12, 13 unused.
// - Only port B pins, serial peripheral, time base wake from stop.
// - Registers sit at consecutive byte addresses, group 0 first.
// - Highest software priority first, ties broken by hardware order.
// - Maskable taken only if enabled and above current level.
// - Entry loads current-level bits from the vector's stored field.
// - Level pairs: 0=10, 1=01, 2=00, 3=11 meaning disabled.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "ipa_cfg.svh"

module interrupt_priority_arbiter #(
  parameter int ADDR_W  = 8,
  parameter int NUM_VEC = `IPA_NUM_VEC
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [7:0]        regRdata,
  input  wire logic [13:0]       irqPending,
  input  wire logic [13:0]       irqEnable,
  input  wire logic              trapReq,
  input  wire logic              instrBoundary,
  input  wire logic              curPrioHighBit,
  input  wire logic              curPrioLowBit,
  input  wire logic              haltMode,
  output logic                   svcValid,
  output ipa_pkg::ipa_src_t      svcKind,
  output logic      [3:0]        svcIndex,
  output logic      [15:0]       svcVector,
  output logic                   newPrioHighBit,
  output logic                   newPrioLowBit,
  output logic                   wakeReq,
  output logic                   maskPending
);
  import ipa_pkg::*;

  // Fixed at fourteen vectors: the register layout has no room for more
  if (NUM_VEC != `IPA_NUM_VEC)
  begin : g_bad_num
    $error("interrupt_priority_arbiter: NUM_VEC must be fourteen");
  end
  if (ADDR_W < 5)
  begin : g_bad_addr
    $error("interrupt_priority_arbiter: ADDR_W too small");
  end

  // Pair to level number; same scheme for stored fields and the CPU pair
  function automatic logic [1:0] pairLevel(input ipa_pair_t pair);
    logic [1:0] lvl;
    case (pair)
      `IPA_PAIR_LEVEL0: lvl = 2'd0;
      `IPA_PAIR_LEVEL1: lvl = 2'd1;
      `IPA_PAIR_LEVEL2: lvl = 2'd2;
      `IPA_PAIR_LEVEL3: lvl = 2'd3;
      default:          lvl = 2'd3;
    endcase
    return lvl;
  endfunction : pairLevel

  // Winner among eligible vectors: {found, index}
  function automatic logic [4:0] pickBest(input logic [13:0] elig, input logic [27:0] flds);
    logic       found;
    logic [3:0] bestIdx;
    logic [1:0] bestLvl;
    logic [1:0] lvl;
    found   = 1'b0;
    bestIdx = 4'h0;
    bestLvl = 2'd0;
    lvl     = 2'd0;
    // Walk from lowest hardware priority up so that ties go to the lower index
    for (int i = 13; i >= 0; i--)
    begin
      lvl = pairLevel(flds[2*i +: 2]);
      if (elig[i] && (!found || lvl >= bestLvl))
      begin
        found   = 1'b1;
        bestIdx = 4'(i);
        bestLvl = lvl;
      end
    end
    return {found, bestIdx};
  endfunction : pickBest

  // Vector address of a maskable index
  function automatic logic [15:0] vecAddr(input logic [3:0] idx);
    return `IPA_VEC_BASE - (16'(idx) * `IPA_VEC_STEP);
  endfunction : vecAddr

  // Register file
  logic [27:0] vecPrioFields;

  ipa_prio_regs #(
    .ADDR_W        (ADDR_W)
  ) u_regs (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .regAddr       (regAddr),
    .regWdata      (regWdata),
    .regWr         (regWr),
    .regRd         (regRd),
    .regRdata      (regRdata),
    .vecPrioFields (vecPrioFields)
  );

  // Registered state and outputs
  ipa_state_t  state_r;
  ipa_state_t  state_nxt;
  logic        svcValid_r;
  logic        svcValid_nxt;
  ipa_src_t    svcKind_r;
  ipa_src_t    svcKind_nxt;
  logic [3:0]  svcIndex_r;
  logic [3:0]  svcIndex_nxt;
  logic [15:0] svcVector_r;
  logic [15:0] svcVector_nxt;
  logic [1:0]  newPrio_r;
  logic [1:0]  newPrio_nxt;
  logic        wakeReq_r;
  logic        wakeReq_nxt;
  logic        maskPending_r;
  logic        maskPending_nxt;

  // Decision wires
  logic [13:0] liveReq;
  logic [13:0] aboveCur;
  logic [13:0] eligible;
  logic [1:0]  curLevel;
  logic [4:0]  bestPick;
  logic        bestFound;
  logic [3:0]  bestIdx;
  ipa_pair_t   bestPair;
  logic        takeTrap;
  logic        takeMask;

  // Requests that exist at all: wired, latched by the source, enabled
  assign liveReq  = irqPending & irqEnable & `IPA_USED_MASK;
  assign curLevel = pairLevel({curPrioHighBit, curPrioLowBit});

  // Compare each stored field against the CPU's current level
  genvar gv;
  generate
    for (gv = 0; gv < 14; gv++)
    begin : g_cmp
      assign aboveCur[gv] = pairLevel(vecPrioFields[2*gv +: 2]) > curLevel;
    end
  endgenerate

  // In deepest stop only wake-capable sources compete
  assign eligible  = liveReq & aboveCur & (haltMode ? `IPA_WAKE_MASK : 14'h3FFF);
  assign bestPick  = pickBest(eligible, vecPrioFields);
  assign bestFound = bestPick[4];
  assign bestIdx   = bestPick[3:0];
  assign bestPair  = vecPrioFields[2*bestIdx +: 2];

  // Trap outranks every maskable and ignores the current level
  assign takeTrap  = instrBoundary && trapReq;
  // Level in effect is the CPU pair; a raised field simply wins the compare again
  assign takeMask  = instrBoundary && !trapReq && bestFound;

  // Next state and service outputs
  always_comb
  begin
    state_nxt       = state_r;
    svcValid_nxt    = 1'b0;
    svcKind_nxt     = svcKind_r;
    svcIndex_nxt    = svcIndex_r;
    svcVector_nxt   = svcVector_r;
    newPrio_nxt     = newPrio_r;
    case (state_r)
      IPA_ST_BOOT:
      begin
        // First service after reset is the reset vector
        svcValid_nxt  = 1'b1;
        svcKind_nxt   = IPA_SRC_RESET;
        svcIndex_nxt  = 4'h0;
        svcVector_nxt = `IPA_VEC_RESET;
        newPrio_nxt   = `IPA_PAIR_LEVEL3;
        state_nxt     = IPA_ST_RUN;
      end
      IPA_ST_RUN:
      begin
        if (takeTrap)
        begin
          svcValid_nxt  = 1'b1;
          svcKind_nxt   = IPA_SRC_TRAP;
          svcIndex_nxt  = 4'h0;
          svcVector_nxt = `IPA_VEC_TRAP;
          newPrio_nxt   = `IPA_PAIR_LEVEL3;
        end
        else if (takeMask)
        begin
          svcValid_nxt  = 1'b1;
          svcKind_nxt   = IPA_SRC_MASK;
          svcIndex_nxt  = bestIdx;
          svcVector_nxt = vecAddr(bestIdx);
          newPrio_nxt   = bestPair;
        end
      end
      default:
      begin
        state_nxt = IPA_ST_BOOT;
      end
    endcase
  end

  // Status levels
  assign wakeReq_nxt     = haltMode && |(liveReq & `IPA_WAKE_MASK);
  assign maskPending_nxt = |liveReq;

  // Sequencing flops
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_r    <= IPA_ST_BOOT;
      svcValid_r <= 1'b0;
      svcKind_r  <= IPA_SRC_RESET;
      svcIndex_r <= 4'h0;
    end
    else
    begin
      state_r    <= state_nxt;
      svcValid_r <= svcValid_nxt;
      svcKind_r  <= svcKind_nxt;
      svcIndex_r <= svcIndex_nxt;
    end
  end

  // Vector and level flops
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      svcVector_r   <= `IPA_VEC_RESET;
      newPrio_r     <= `IPA_PAIR_LEVEL3;
      wakeReq_r     <= 1'b0;
      maskPending_r <= 1'b0;
    end
    else
    begin
      svcVector_r   <= svcVector_nxt;
      newPrio_r     <= newPrio_nxt;
      wakeReq_r     <= wakeReq_nxt;
      maskPending_r <= maskPending_nxt;
    end
  end

  // Outputs straight from flops
  assign svcValid       = svcValid_r;
  assign svcKind        = svcKind_r;
  assign svcIndex       = svcIndex_r;
  assign svcVector      = svcVector_r;
  assign newPrioHighBit = newPrio_r[1];
  assign newPrioLowBit  = newPrio_r[0];
  assign wakeReq        = wakeReq_r;
  assign maskPending    = maskPending_r;

endmodule : interrupt_priority_arbiter

// ===== verilog/ipa_prio_regs.sv
// Four byte-wide software priority registers with read port
`timescale 1ns/100ps
`include "ipa_cfg.svh"

module ipa_prio_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [7:0]        regRdata,
  output logic      [27:0]       vecPrioFields
);
  import ipa_pkg::*;

  // Offsets need at least five address bits
  if (ADDR_W < 5)
  begin : g_bad_addr
    $error("ipa_prio_regs: ADDR_W too small for the register offsets");
  end

  logic [7:0]  group_r [4];
  logic [7:0]  group_nxt [4];
  logic [7:0]  regRdata_r;
  logic [7:0]  regRdata_nxt;
  logic [3:0]  hitSel;
  logic [7:0]  rdMux;

  // Address decode
  assign hitSel[0] = (regAddr == ADDR_W'(`IPA_OFS_GROUP0));
  assign hitSel[1] = (regAddr == ADDR_W'(`IPA_OFS_GROUP1));
  assign hitSel[2] = (regAddr == ADDR_W'(`IPA_OFS_GROUP2));
  assign hitSel[3] = (regAddr == ADDR_W'(`IPA_OFS_GROUP3));

  // Merge one write; a lowest-level pair keeps its old value
  function automatic logic [7:0] mergeWrite(input logic [7:0] oldV, input logic [7:0] newV);
    logic [7:0] res;
    res = oldV;
    for (int f = 0; f < `IPA_FIELDS_PER_REG; f++)
    begin
      if (newV[2*f +: 2] != `IPA_PAIR_LEVEL0)
        res[2*f +: 2] = newV[2*f +: 2];
    end
    return res;
  endfunction : mergeWrite

  // Next register values
  always_comb
  begin
    for (int r = 0; r < 4; r++)
    begin
      group_nxt[r] = group_r[r];
      if (regWr && hitSel[r])
        group_nxt[r] = mergeWrite(group_r[r], regWdata);
    end
    group_nxt[3] = group_nxt[3] | `IPA_GROUP3_RO_MASK;
  end

  // Read selection, unmapped reads give zero
  assign rdMux = hitSel[0] ? group_r[0] :
                 hitSel[1] ? group_r[1] :
                 hitSel[2] ? group_r[2] :
                 hitSel[3] ? (group_r[3] | `IPA_GROUP3_RO_MASK) : 8'h00;
  assign regRdata_nxt = regRd ? rdMux : 8'h00;

  // Storage
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      for (int r = 0; r < 4; r++)
        group_r[r] <= `IPA_PRIO_RESET;
      regRdata_r <= 8'h00;
    end
    else
    begin
      for (int r = 0; r < 4; r++)
        group_r[r] <= group_nxt[r];
      regRdata_r <= regRdata_nxt;
    end
  end

  assign regRdata      = regRdata_r;
  // Fields of vectors 0..13, two bits each, lowest index lowest
  assign vecPrioFields = {group_r[3][3:0], group_r[2], group_r[1], group_r[0]};

endmodule : ipa_prio_regs
